/* File: pkg/upc_params.svh */
/*
  Constants of the USB port power state controller: register offsets,
  status and configuration bit positions, reset values and timing counts.
  Assumes a 250 MHz clock; every count is derived from a time in ns.
*/
`ifndef UPC_PARAMS_SVH
`define UPC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define UPC_ADDR_STATUS 4'h0
`define UPC_ADDR_CONFIG 4'h4
`define UPC_ADDR_STATE 4'h8

`define UPC_ST_ERR 0
`define UPC_ST_ATT 1
`define UPC_ST_ATTACH_PIN_STATUS_BIT 2
`define UPC_ST_REM 3
`define UPC_CFG_HOLD 0
`define UPC_CFG_BUS_CTL 1
`define UPC_CFG_RESET 2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UPC_CLK_PERIOD_NS 4
`define UPC_T_RETRY_NS 2000
`define UPC_T_TEST_NS 400
`define UPC_T_ATT_QUAL_NS 200
`define UPC_T_REM_QUAL_NS 200
`define UPC_T_DISCHARGE_NS 400
// Least times round up, the discharge limit rounds down.
`define UPC_RETRY_CYC \
  ((`UPC_T_RETRY_NS + `UPC_CLK_PERIOD_NS - 1) / `UPC_CLK_PERIOD_NS)
`define UPC_TEST_CYC \
  ((`UPC_T_TEST_NS + `UPC_CLK_PERIOD_NS - 1) / `UPC_CLK_PERIOD_NS)
`define UPC_ATT_QUAL_CYC \
  ((`UPC_T_ATT_QUAL_NS + `UPC_CLK_PERIOD_NS - 1) / `UPC_CLK_PERIOD_NS)
`define UPC_REM_QUAL_CYC \
  ((`UPC_T_REM_QUAL_NS + `UPC_CLK_PERIOD_NS - 1) / `UPC_CLK_PERIOD_NS)
`define UPC_DISCHARGE_CYC (`UPC_T_DISCHARGE_NS / `UPC_CLK_PERIOD_NS)

`endif

/* File: pkg/upc_pkg.sv */
/*
  Types of the USB port power state controller: states, active modes and
  the packed carriers for fault inputs and switch controls.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package upc_pkg;

  typedef enum logic [2:0] {
    UPC_DETECT = 3'h0,
    UPC_ATTACHED = 3'h1,
    UPC_ACTIVE = 3'h3,
    UPC_RENEG = 3'h2,
    UPC_ERROR = 3'h6,
    UPC_TEST = 3'h7,
    UPC_DISCH = 3'h5
  } upc_state_t;

  typedef enum logic [2:0] {
    UPC_M_OFF = 3'h0,
    UPC_M_DCE = 3'h1,
    UPC_M_PASS = 3'h2,
    UPC_M_DCP = 3'h3,
    UPC_M_SDP = 3'h4,
    UPC_M_CDP = 3'h5
  } upc_mode_t;

  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
    logic back_voltage;
    logic discharge_err;
    logic over_temp;
  } upc_fault_t;

  typedef struct packed {
    logic port;
    logic bypass;
    logic discharge;
    logic hs_data;
    logic trip_limit;
  } upc_sw_t;

endpackage

/* File: src/upc_ctrl.sv */
/*
  USB port power state controller: Detect, Active, Error and recovery
  sequencing, attach and removal detection, Active mode selection and
  VBUS cycling, with a classic Wishbone register slave.
  Assumes analog comparators deliver load, supply and fault levels as
  asynchronous pins, and that the switches obey the controls given.
*/
`timescale 1ns/1ps
`default_nettype none
`include "upc_params.svh"

module upc_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control pins
  input wire logic fault_latch_pin_i,
  input wire logic port_power_enable_i,
  input wire logic sel1_i,
  input wire logic sel2_i,
  input wire logic emul_en_i,
  input wire logic attach_detect_enable_i,
  // Analog monitors
  input wire upc_pkg::upc_fault_t fault_i,
  input wire logic vs_ok_i,
  input wire logic load_above_attach_i,
  input wire logic load_below_removal_i,
  // Status and switch outputs
  output logic alert_n_o,
  output logic attach_detect_n_o,
  output logic attach_detect_n_oe_o,
  output upc_pkg::upc_sw_t sw_o,
  output logic bypass_limit_o,
  output upc_pkg::upc_mode_t mode_o
);
  import upc_pkg::*;
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NPIN = 16;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  wire [NPIN-1:0] pin_raw = {fault_latch_pin_i, port_power_enable_i,
    sel1_i, sel2_i, emul_en_i, attach_detect_enable_i, fault_i, vs_ok_i,
    load_above_attach_i, load_below_removal_i, 1'b0};
  always_ff @(posedge clk_i) begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
  end
  wire latch_pin = pin_sync[15];
  wire port_power_enable = pin_sync[14];
  wire [2:0] sel = pin_sync[13:11];
  wire det_en = pin_sync[10];
  wire [5:0] faults = pin_sync[9:4];
  wire vs_ok = pin_sync[3];
  wire load_hi = pin_sync[2];
  wire load_lo = pin_sync[1];

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  function automatic upc_mode_t decode_mode(input logic [2:0] s);
    case (s)
      3'h1, 3'h5: decode_mode = UPC_M_DCE;
      3'h2, 3'h6: decode_mode = UPC_M_PASS;
      3'h3: decode_mode = UPC_M_DCP;
      3'h4: decode_mode = UPC_M_SDP;
      3'h7: decode_mode = UPC_M_CDP;
      default: decode_mode = UPC_M_OFF;
    endcase
  endfunction
  function automatic logic is_bc(input upc_mode_t m);
    is_bc = (m == UPC_M_SDP) || (m == UPC_M_DCP) || (m == UPC_M_CDP);
  endfunction
  // The mode is registered so a change is judged one cycle after it.
  upc_mode_t mode;
  upc_mode_t req_mode;
  logic port_power_enable_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_mode <= UPC_M_OFF;
      port_power_enable_q <= 1'b0;
    end else begin
      req_mode <= decode_mode(sel);
      port_power_enable_q <= port_power_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  upc_state_t state;
  upc_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] qcnt;
  logic [3:0] status;
  logic [1:0] cfg;
  logic adet_low;
  wire err_any = |faults;
  wire latched = cfg[`UPC_CFG_BUS_CTL] ? cfg[`UPC_CFG_HOLD] : latch_pin;
  wire pwr_fall = port_power_enable_q && !port_power_enable;
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire wr_status = wb_wr && (wb_adr_i == `UPC_ADDR_STATUS);
  wire wr_config = wb_wr && (wb_adr_i == `UPC_ADDR_CONFIG);
  wire err_clr = wr_status && wb_dat_i[`UPC_ST_ERR] && status[`UPC_ST_ERR];
  wire cnt_done_retry = cnt >= 16'(`UPC_RETRY_CYC - 1);
  wire cnt_done_test = cnt >= 16'(`UPC_TEST_CYC - 1);
  wire cnt_done_dis = cnt >= 16'(`UPC_DISCHARGE_CYC - 1);
  wire attach_ev = (state == UPC_DETECT) && det_en && load_hi &&
    (qcnt >= 16'(`UPC_ATT_QUAL_CYC - 1));
  wire rem_qual = load_lo && (qcnt >= 16'(`UPC_REM_QUAL_CYC - 1));
  wire removal_ev = det_en && rem_qual &&
    (state == UPC_ACTIVE || state == UPC_ATTACHED);
  wire can_enter = port_power_enable && vs_ok && (req_mode != UPC_M_OFF);
  // Pass-through needs no discharge; every charger mode is entered fresh.
  wire enter_reneg = req_mode != UPC_M_PASS;
  wire bc_change = is_bc(mode) && is_bc(req_mode) &&
    (req_mode != mode);
  // Pass-through holds with enable off; reselect is only honoured with it on.
  wire pass_hold = (mode == UPC_M_PASS) && !port_power_enable;

  // ----------------------------------------------------------------------
  // State transitions
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      UPC_DETECT: begin
        if (attach_ev) begin
          next_state = UPC_ATTACHED;
        end else if (!det_en && can_enter) begin
          next_state = enter_reneg ? UPC_RENEG : UPC_ACTIVE;
        end
      end
      UPC_ATTACHED: begin
        if (removal_ev) begin
          next_state = UPC_DISCH;
        end else if (can_enter) begin
          next_state = enter_reneg ? UPC_RENEG : UPC_ACTIVE;
        end
      end
      UPC_RENEG: begin
        if (cnt_done_dis) begin
          next_state = UPC_ACTIVE;
        end
      end
      UPC_ACTIVE: begin
        if (err_any) begin
          next_state = UPC_ERROR;
        end else if (removal_ev) begin
          next_state = UPC_DISCH;
        end else if (pass_hold) begin
          next_state = UPC_ACTIVE;
        end else if (!port_power_enable || req_mode == UPC_M_OFF) begin
          next_state = UPC_DETECT;
        end else if (bc_change) begin
          next_state = UPC_RENEG;
        end else if (req_mode != mode) begin
          next_state = enter_reneg ? UPC_RENEG : UPC_ACTIVE;
        end
      end
      UPC_ERROR: begin
        if (latched ? (pwr_fall || err_clr) : cnt_done_retry) begin
          next_state = UPC_TEST;
        end
      end
      UPC_TEST: begin
        if (err_any) begin
          next_state = UPC_ERROR;
        end else if (cnt_done_test) begin
          next_state = UPC_ACTIVE;
        end
      end
      UPC_DISCH: begin
        if (cnt_done_dis) begin
          next_state = UPC_DETECT;
        end
      end
      default: next_state = UPC_DETECT;
    endcase
  end

  // ----------------------------------------------------------------------
  // Switch controls, registered from the next state
  // ----------------------------------------------------------------------
  wire next_port = (next_state == UPC_ACTIVE) || (next_state == UPC_TEST);
  wire next_byp = (next_state == UPC_DETECT) ||
    (next_state == UPC_ATTACHED);
  wire next_dis = (next_state == UPC_RENEG) || (next_state == UPC_DISCH);
  wire mode_load = ((next_state == UPC_RENEG) || (next_state == UPC_ACTIVE))
    && !(state == UPC_ACTIVE && pass_hold);
  upc_mode_t next_mode;
  assign next_mode = mode_load ? req_mode : mode;
  wire next_pass = (next_mode == UPC_M_PASS) || (next_mode == UPC_M_SDP);
  wire next_hs = next_port && (next_pass || next_mode == UPC_M_CDP);
  wire q_run = (next_state == state) &&
    ((state == UPC_DETECT) ? load_hi : load_lo);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= UPC_DETECT;
      mode <= UPC_M_OFF;
      cnt <= 16'h0000;
      qcnt <= 16'h0000;
      sw_o <= '0;
      adet_low <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 16'h0000 : cnt + 16'h0001;
      mode <= next_mode;
      // One qualification counter serves attach and removal timing. It
      // restarts on each state change, so a late load is no removal.
      qcnt <= q_run ? qcnt + 16'h0001 : 16'h0000;
      sw_o.port <= next_port;
      sw_o.bypass <= next_byp && !next_port;
      sw_o.discharge <= next_dis;
      sw_o.hs_data <= next_hs;
      sw_o.trip_limit <= next_port && next_pass;
      if (attach_ev) begin
        adet_low <= 1'b1;
      end else if (removal_ev) begin
        adet_low <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status, configuration and bus slave
  // ----------------------------------------------------------------------
  wire [3:0] st_set = {removal_ev, attach_ev, attach_ev,
    next_state == UPC_ERROR && state != UPC_ERROR};
  wire [3:0] st_clr = wr_status ? wb_dat_i[3:0] : 4'h0;
  wire [31:0] rd_mux = (wb_adr_i == `UPC_ADDR_STATUS) ? {28'h0, status} :
    (wb_adr_i == `UPC_ADDR_CONFIG) ? {30'h0, cfg} :
    (wb_adr_i == `UPC_ADDR_STATE) ? {25'h0, mode, 1'b0, state} : 32'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 4'h0;
      cfg <= `UPC_CFG_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      // A new event wins over a clear written in the same cycle.
      status <= (status & ~st_clr) | st_set;
      if (wr_config) begin
        cfg <= wb_dat_i[1:0];
      end
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
    end
  end
  // The alert follows live causes, not the sticky bit, so software that
  // never clears the bit still sees it released after recovery.
  assign alert_n_o = !(state == UPC_ERROR || state == UPC_TEST ||
    err_any);
  assign attach_detect_n_o = 1'b0;
  assign attach_detect_n_oe_o = adet_low;
  assign bypass_limit_o = sw_o.bypass;
  assign mode_o = mode;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_no_both_sw;
    @(posedge clk_i) disable iff (rst_i)
      !(sw_o.port && sw_o.bypass);
  endproperty
  a_no_both_sw: assert property (p_no_both_sw)
    else $error("bypass and port switch closed together");
  property p_err_entry;
    @(posedge clk_i) disable iff (rst_i)
      (state == UPC_ACTIVE && err_any) |=> (state == UPC_ERROR) && !alert_n_o;
  endproperty
  a_err_entry: assert property (p_err_entry)
    else $error("error not entered at once");
  property p_auto_retry;
    @(posedge clk_i) disable iff (rst_i)
      (state == UPC_ERROR && !latched) [*8] |-> ##[1:600] (state != UPC_ERROR);
  endproperty
  a_auto_retry: assert property (p_auto_retry)
    else $error("auto retry did not leave error state");
  property p_latched_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state == UPC_ERROR && latched && !pwr_fall && !err_clr) |=>
        (state == UPC_ERROR);
  endproperty
  a_latched_hold: assert property (p_latched_hold)
    else $error("latched error left without command");
  property p_latched_cmd;
    @(posedge clk_i) disable iff (rst_i)
      (state == UPC_ERROR && latched && pwr_fall) |=> (state == UPC_TEST);
  endproperty
  a_latched_cmd: assert property (p_latched_cmd)
    else $error("recovery command did not start a check");
  property p_hs_detect;
    @(posedge clk_i) disable iff (rst_i)
      (state == UPC_DETECT) |-> !sw_o.hs_data;
  endproperty
  a_hs_detect: assert property (p_hs_detect)
    else $error("data switch closed in detect");
  property p_attach;
    @(posedge clk_i) disable iff (rst_i)
      attach_ev |=> attach_detect_n_oe_o && status[`UPC_ST_ATT] &&
        status[`UPC_ST_ATTACH_PIN_STATUS_BIT];
  endproperty
  a_attach: assert property (p_attach)
    else $error("attach event not reported");
  property p_removal;
    @(posedge clk_i) disable iff (rst_i)
      removal_ev |=> !attach_detect_n_oe_o && !sw_o.port && !sw_o.bypass &&
        status[`UPC_ST_REM] ##[1:120] (state == UPC_DETECT);
  endproperty
  a_removal: assert property (p_removal)
    else $error("removal sequence wrong");
  property p_bypass_lim;
    @(posedge clk_i) disable iff (rst_i)
      sw_o.bypass |-> bypass_limit_o && !sw_o.port &&
        (state == UPC_DETECT || state == UPC_ATTACHED);
  endproperty
  a_bypass_lim: assert property (p_bypass_lim)
    else $error("bypass limit not applied");
  property p_pass_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state == UPC_ACTIVE && mode == UPC_M_PASS && !port_power_enable && !err_any &&
        !removal_ev) |=> (state == UPC_ACTIVE) && $stable(mode);
  endproperty
  a_pass_hold: assert property (p_pass_hold)
    else $error("pass-through left with enable off");

endmodule // upc_ctrl

`default_nettype wire

/* File: test/upc_device_model.sv */
/*
  Behavioural model of the portable device on the USB port.
  Assumes the controller's switch controls tell whether VBUS is fed.
*/
`timescale 1ns/1ps
`default_nettype none

module upc_device_model (
  // Clock and bench control
  input wire logic clk_i,
  input wire logic plugged_i,
  input wire logic [3:0] lag_i,
  // Port supply as seen by the device
  input wire upc_pkg::upc_sw_t sw_i,
  // Load seen by the current monitors
  output logic load_above_o,
  output logic load_below_o
);
  import upc_pkg::*;
  // --------------------------------------------------------------------
  // Load draw
  // --------------------------------------------------------------------
  // A device only draws current a few cycles after VBUS appears, so a
  // slow lag exercises the qualification timers with a late load.
  logic [3:0] pwr_cnt;
  wire logic powered = plugged_i && (sw_i.port || sw_i.bypass);
  wire logic drawing = powered && (pwr_cnt == lag_i);

  always_ff @(posedge clk_i) begin
    if (!powered) begin
      pwr_cnt <= 4'h0;
    end else if (pwr_cnt != lag_i) begin
      pwr_cnt <= pwr_cnt + 4'h1;
    end
  end

  assign load_above_o = drawing;
  assign load_below_o = !drawing;
endmodule // upc_device_model

`default_nettype wire

/* File: test/test_usb_port_power_state_control.sv */
/*
  Self-checking bench of upc_ctrl with a portable device model.
  Assumes upc_pkg and upc_params.svh are on the compile path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "upc_params.svh"

module test_usb_port_power_state_control;
  import upc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, hold, en, s1, s2, emu, det_en;
  logic vs_ok, plugged;
  logic [3:0] adr, lag;
  logic [31:0] wdat, rdat, rnd;
  upc_fault_t flt;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, alert_n, oe, ad_n, byp_lim, ld_hi, ld_lo;
  wire upc_sw_t sw;
  wire upc_mode_t mode;
  int n_mismatch, n_tests, n;
  int seq[$] = '{3, 7, 4, 1, 5, 2, 6};
  upc_mode_t tbl[8] = '{UPC_M_OFF, UPC_M_DCE, UPC_M_PASS, UPC_M_DCP,
    UPC_M_SDP, UPC_M_DCE, UPC_M_PASS, UPC_M_CDP};
  upc_mode_t em, pm;
  bit d;

  upc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fault_latch_pin_i(hold), .port_power_enable_i(en), .sel1_i(s1),
    .sel2_i(s2), .emul_en_i(emu), .attach_detect_enable_i(det_en),
    .fault_i(flt), .vs_ok_i(vs_ok), .load_above_attach_i(ld_hi),
    .load_below_removal_i(ld_lo), .alert_n_o(alert_n),
    .attach_detect_n_o(ad_n), .attach_detect_n_oe_o(oe), .sw_o(sw),
    .bypass_limit_o(byp_lim), .mode_o(mode));

  upc_device_model u_dev (.clk_i(clk_i), .plugged_i(plugged),
    .lag_i(lag), .sw_i(sw), .load_above_o(ld_hi), .load_below_o(ld_lo));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] dt);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 40) n_mismatch++;
  endtask

  task automatic state_is(input upc_state_t s);
    bus(1'b0, `UPC_ADDR_STATE, 32'h0);
    chk(rdat[2:0], s);
  endtask

  // Waits for port (0), attach pin (1) or active mode (2) to show v.
  task automatic wait_on(input int which, input logic [2:0] v,
                         input int lim);
    n = 0;
    d = 0;
    while (n < lim) begin
      @(posedge clk_i);
      n++;
      if (sw.discharge === 1'b1) d = 1;
      if ((which == 0 && sw.port === v[0]) || (which == 1 && oe === v[0])
          || (which == 2 && mode === v && sw.port === 1'b1)) break;
    end
    if (n >= lim) n_mismatch++;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #(4 * 20000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {rst_i, en, det_en} = 3'b111;
    {cyc, stb, we, hold, vs_ok, plugged} = 6'h0;
    {s1, s2, emu} = 3'b011;
    {adr, lag, wdat, flt} = '0;
    rnd = 32'hB681;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({sw.port, sw.bypass, sw.hs_data, byp_lim, oe, alert_n, ad_n},
        7'h2A);
    bus(1'b0, `UPC_ADDR_CONFIG, 32'h0);
    chk(rdat, 32'h0);
    rnd = lfsr(rnd);
    bus(1'b1, 4'hC, rnd);
    bus(1'b0, 4'hC, 32'h0);
    chk(rdat, 32'h0);
    $display("test reset and bus done");
    plugged <= 1'b1;
    wait_on(1, 3'h1, 200);
    chk(n >= `UPC_ATT_QUAL_CYC, 1'b1);
    bus(1'b0, `UPC_ADDR_STATUS, 32'h0);
    chk(rdat[2:1], 2'b11);
    repeat (20) @(posedge clk_i);
    chk(sw.port, 1'b0);
    vs_ok <= 1'b1;
    lag <= 4'hC;
    wait_on(2, UPC_M_DCP, 400);
    chk(sw.bypass, 1'b0);
    pm = UPC_M_DCP;
    $display("test attach done");
    foreach (seq[i]) begin
      {s1, s2, emu} <= 3'(seq[i]);
      em = tbl[seq[i]];
      wait_on(2, em, 400);
      if (em != pm) chk(d, em != UPC_M_PASS);
      chk(mode, em);
      pm = em;
    end
    chk({sw.hs_data, sw.trip_limit}, 2'b11);
    en <= 1'b0;
    {s1, s2, emu} <= 3'b011;
    repeat (40) @(posedge clk_i);
    chk(mode, UPC_M_PASS);
    {s1, s2, emu} <= 3'b010;
    repeat (10) @(posedge clk_i);
    en <= 1'b1;
    repeat (10) @(posedge clk_i);
    {s1, s2, emu} <= 3'b011;
    wait_on(2, UPC_M_DCP, 400);
    chk(d, 1'b1);
    $display("test modes done");
    rnd = lfsr(rnd);
    flt <= upc_fault_t'(6'h1 << (rnd % 6));
    repeat (8) @(posedge clk_i);
    chk({alert_n, sw.port}, 2'b00);
    state_is(UPC_ERROR);
    flt <= '0;
    wait_on(0, 3'h1, `UPC_RETRY_CYC + 100);
    chk(n > `UPC_RETRY_CYC - 30, 1'b1);
    repeat (`UPC_TEST_CYC + 10) @(posedge clk_i);
    state_is(UPC_ACTIVE);
    chk(alert_n, 1'b1);
    hold <= 1'b1;
    rnd = lfsr(rnd);
    flt <= upc_fault_t'(6'h1 << (rnd % 6));
    repeat (8) @(posedge clk_i);
    state_is(UPC_ERROR);
    flt <= '0;
    repeat (`UPC_RETRY_CYC + `UPC_TEST_CYC + 100) @(posedge clk_i);
    state_is(UPC_ERROR);
    bus(1'b1, `UPC_ADDR_STATUS, 32'h1);
    wait_on(0, 3'h1, 100);
    repeat (`UPC_TEST_CYC + 10) @(posedge clk_i);
    state_is(UPC_ACTIVE);
    hold <= 1'b0;
    bus(1'b1, `UPC_ADDR_CONFIG, 32'h3);
    bus(1'b0, `UPC_ADDR_CONFIG, 32'h0);
    chk(rdat, 32'h3);
    rnd = lfsr(rnd);
    flt <= upc_fault_t'(6'h1 << (rnd % 6));
    repeat (8) @(posedge clk_i);
    flt <= '0;
    repeat (`UPC_RETRY_CYC + 20) @(posedge clk_i);
    state_is(UPC_ERROR);
    en <= 1'b0;
    repeat (6) @(posedge clk_i);
    en <= 1'b1;
    repeat (`UPC_TEST_CYC + 10) @(posedge clk_i);
    state_is(UPC_ACTIVE);
    bus(1'b1, `UPC_ADDR_CONFIG, 32'h0);
    $display("test faults done");
    plugged <= 1'b0;
    wait_on(1, 3'h0, 200);
    chk(n >= `UPC_REM_QUAL_CYC, 1'b1);
    chk({sw.port, sw.bypass}, 2'b00);
    repeat (`UPC_DISCHARGE_CYC + 10) @(posedge clk_i);
    bus(1'b0, `UPC_ADDR_STATUS, 32'h0);
    chk(rdat[3], 1'b1);
    state_is(UPC_DETECT);
    chk({sw.port, sw.bypass}, 2'b01);
    $display("test removal done");
    {s1, s2, emu} <= 3'b010;
    repeat (5) @(posedge clk_i);
    det_en <= 1'b0;
    wait_on(2, UPC_M_PASS, 100);
    chk({d, sw.bypass, sw.hs_data}, 3'b001);
    $display("test direct pass-through done");
    end_of_test();
  end
endmodule // test_usb_port_power_state_control

`default_nettype wire
